/* File: design/spe_pkg.sv */
// Package for the switching-period enable counter: counts, thresholds, timing.
// Assumes a 20 MHz core clock; all times are converted to cycles here.
package spe_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS              = 50;
  // Disable qualifying interval (long period), microseconds
  localparam int unsigned DISABLE_QUALIFY_INTERVAL_US = 1000;
  // Enable qualifying interval (short period), microseconds
  localparam int unsigned ENABLE_QUALIFY_INTERVAL_US  = 200;
  // Cycle detect minimum low time, nanoseconds (least time: round up)
  localparam int unsigned CYCLE_DETECT_MIN_TIME_NS    = 500;
  // Wake pulse width and repeat period, nanoseconds
  localparam int unsigned WAKE_PULSE_NS               = 1000;
  localparam int unsigned WAKE_REPEAT_NS              = 30000;

  localparam int unsigned DISABLE_QUALIFY_CYCLES = (DISABLE_QUALIFY_INTERVAL_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned ENABLE_QUALIFY_CYCLES  = (ENABLE_QUALIFY_INTERVAL_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CYCLE_DETECT_MIN_CYCLES =
    (CYCLE_DETECT_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_PULSE_CYCLES  = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_REPEAT_CYCLES = WAKE_REPEAT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam int unsigned DISABLE_COUNT = 63;
  localparam int unsigned ENABLE_COUNT  = 32;
  localparam int unsigned COUNT_W       = 6;

  // Droop reference ratio: 97 / 100 of the sampled supply
  localparam int unsigned DROOP_NUM = 97;
  localparam int unsigned DROOP_DEN = 100;

  typedef enum logic [1:0] {
    SPE_RECT_ON  = 2'b01,
    SPE_RECT_OFF = 2'b10
  } spe_rect_state_e;

endpackage : spe_pkg

/* File: design/spe_period_timer.sv */
// Saturating period timer restarted by a one-cycle pulse.
// Assumes restart_in is synchronous to core_clk_in.
`timescale 1ns/1ps
`default_nettype none
module spe_period_timer #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  input  wire logic             restart_in,
  output var  logic [WIDTH-1:0] count_out
);
  // Restart loads one so the count equals cycles since the pulse
  always_ff @(posedge core_clk_in) begin
    if (rst_in || restart_in) begin
      count_out <= {{(WIDTH-1){1'b0}}, 1'b1};
    end else if (count_out != {WIDTH{1'b1}}) begin
      count_out <= count_out + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule : spe_period_timer
`default_nettype wire

/* File: design/spe_switching_period_enable_counter.sv */
// Switching-period enable counter with power-cycle detect and droop wake-up.
// Assumes all inputs synchronous to core_clk_in; rst_in is the lockout reset.
//
// Functional notes
// - Enable output released high after power-up
// - Time periods, compare against both intervals
// - 63 consecutive long periods pull output low
// - Short period clears consecutive disable count
// - Separate disable and enable intervals give hysteresis
// - 32 short periods release output high
// - Re-enable count cumulative, long periods ignored
// - Wake event leaves output and counts alone
// - Droop three percent triggers wake in both states
// - Enable output is open-drain to ground
// - Detect pulse only after qualified low time
// - Droop reference refreshed on every detect pulse
// - Wake pulses repeat until detect or lockout
// - Everything disabled during undervoltage lockout
`timescale 1ns/1ps
`default_nettype none
module spe_switching_period_enable_counter
  import spe_pkg::*;
#(
  parameter int unsigned PERIOD_W = 16,
  parameter int unsigned SUPPLY_W = 12,
  parameter int unsigned DISABLE_QUALIFY_CYC = spe_pkg::DISABLE_QUALIFY_CYCLES,
  parameter int unsigned ENABLE_QUALIFY_CYC  = spe_pkg::ENABLE_QUALIFY_CYCLES
) (
  input  wire logic                core_clk_in,
  input  wire logic                rst_in,
  input  wire logic                wake_below_threshold_in,
  input  wire logic                demag_end_in,
  input  wire logic [SUPPLY_W-1:0] supply_level_in,
  output logic                     rectifier_enable_output_oe_out,
  output logic                     rectifier_enable_output_out,
  output logic                     wake_oe_out,
  output logic                     wake_out,
  output logic                     power_cycle_detect_out
);
  import spe_pkg::*;

  localparam int unsigned LOWT_W = 8;
  localparam int unsigned WAKE_W = 12;
  localparam logic [COUNT_W-1:0]  DIS_MAX    = COUNT_W'(DISABLE_COUNT);
  localparam logic [COUNT_W-1:0]  EN_MAX     = COUNT_W'(ENABLE_COUNT);
  localparam logic [COUNT_W-1:0]  CNT_ONE    = COUNT_W'(1);
  localparam logic [LOWT_W-1:0]   LOWT_MIN   = LOWT_W'(CYCLE_DETECT_MIN_CYCLES);
  localparam logic [LOWT_W-1:0]   LOWT_ONE   = LOWT_W'(1);
  localparam logic [WAKE_W-1:0]   WAKE_ONE   = WAKE_W'(1);
  localparam logic [WAKE_W-1:0]   WAKE_PULSE = WAKE_W'(WAKE_PULSE_CYCLES);
  localparam logic [WAKE_W-1:0]   WAKE_REP   = WAKE_W'(WAKE_REPEAT_CYCLES);
  localparam logic [PERIOD_W-1:0] DIS_THR    = PERIOD_W'(DISABLE_QUALIFY_CYC);
  localparam logic [PERIOD_W-1:0] EN_THR     = PERIOD_W'(ENABLE_QUALIFY_CYC);
  localparam int unsigned PROD_W = SUPPLY_W + 7;

  spe_rect_state_e         rect_state;
  logic [COUNT_W-1:0]      disable_count;
  logic [COUNT_W-1:0]      enable_count;
  logic [LOWT_W-1:0]       low_time;
  logic                    low_qualified;
  logic                    detect_pulse;
  logic [PERIOD_W-1:0]     period;
  logic                    period_long;
  logic                    period_short;
  logic                    seen_first;
  logic [SUPPLY_W-1:0]     droop_reference;
  logic                    reference_valid;
  logic                    droop;
  logic                    wake_active;
  logic [WAKE_W-1:0]       wake_timer;
  logic [PROD_W-1:0]       scaled;

  // ----------------------------------------------------------------
  // Power-cycle detection
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      low_time <= '0;
    end else if (!wake_below_threshold_in || wake_oe_out || detect_pulse) begin
      // Own wake drive or a taken detect restarts qualification
      low_time <= '0;
    end else if (low_time != {LOWT_W{1'b1}}) begin
      low_time <= low_time + LOWT_ONE;
    end
  end

  assign low_qualified = (low_time > LOWT_MIN);
  assign detect_pulse  = demag_end_in && low_qualified && !rst_in;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      power_cycle_detect_out <= 1'b0;
    end else begin
      power_cycle_detect_out <= detect_pulse;
    end
  end

  // ----------------------------------------------------------------
  // Period timing
  // ----------------------------------------------------------------
  spe_period_timer #(
    .WIDTH (PERIOD_W)
  ) i_spe_period_timer (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .restart_in  (detect_pulse),
    .count_out   (period)
  );

  assign period_long  = (period > DIS_THR);
  assign period_short = (period < EN_THR);

  // First detect after lockout only starts timing
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      seen_first <= 1'b0;
    end else if (detect_pulse) begin
      seen_first <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Disable and enable counts
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      disable_count <= '0;
    end else if (detect_pulse && seen_first && rect_state == SPE_RECT_ON) begin
      if (!period_long) begin
        disable_count <= '0;
      end else if (disable_count != DIS_MAX) begin
        disable_count <= disable_count + CNT_ONE;
      end
    end else if (rect_state == SPE_RECT_OFF) begin
      disable_count <= '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      enable_count <= '0;
    end else if (rect_state == SPE_RECT_ON) begin
      enable_count <= '0;
    end else if (detect_pulse && seen_first && period_short && enable_count != EN_MAX) begin
      enable_count <= enable_count + CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Enable output state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rect_state <= SPE_RECT_ON;
    end else begin
      case (rect_state)
        SPE_RECT_ON: begin
          if (disable_count == DIS_MAX) begin
            rect_state <= SPE_RECT_OFF;
          end
        end
        SPE_RECT_OFF: begin
          if (enable_count == EN_MAX) begin
            rect_state <= SPE_RECT_ON;
          end
        end
        default: begin
          rect_state <= SPE_RECT_ON;
        end
      endcase
    end
  end

  // Open drain: driver on pulls low, off releases
  assign rectifier_enable_output_out    = 1'b0;
  assign rectifier_enable_output_oe_out = (rect_state == SPE_RECT_OFF);

  // ----------------------------------------------------------------
  // Droop reference and wake-up
  // ----------------------------------------------------------------
  assign scaled = (PROD_W'(supply_level_in) * PROD_W'(DROOP_NUM)) / PROD_W'(DROOP_DEN);

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      droop_reference <= '0;
      reference_valid <= 1'b0;
    end else if (detect_pulse) begin
      droop_reference <= scaled[SUPPLY_W-1:0];
      reference_valid <= 1'b1;
    end
  end

  // Droop check independent of enable state and counts
  assign droop = reference_valid && (supply_level_in < droop_reference);

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wake_active <= 1'b0;
    end else if (detect_pulse) begin
      wake_active <= 1'b0;
    end else if (droop) begin
      wake_active <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in || !wake_active) begin
      wake_timer <= '0;
    end else if (wake_timer >= WAKE_REP - WAKE_ONE) begin
      wake_timer <= '0;
    end else begin
      wake_timer <= wake_timer + WAKE_ONE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wake_oe_out <= 1'b0;
    end else begin
      wake_oe_out <= wake_active && !detect_pulse && (wake_timer < WAKE_PULSE);
    end
  end

  assign wake_out = 1'b0;

endmodule : spe_switching_period_enable_counter
`default_nettype wire

/* File: tb/spe_props.sv */
// Port checker for the switching-period enable counter.
// Assumes the bind below and one core clock domain.
`timescale 1ns/1ps
`default_nettype none
module spe_props (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic demag_end_in,
  input wire logic rectifier_enable_output_oe_out,
  input wire logic rectifier_enable_output_out,
  input wire logic wake_oe_out,
  input wire logic wake_out,
  input wire logic power_cycle_detect_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  sequence s_pulse_body;
    ##19 wake_oe_out ##1 !wake_oe_out;
  endsequence
  sequence s_quiet_det;
    !power_cycle_detect_out [*8];
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_drive_zero: assert property (rectifier_enable_output_out == 1'b0 && wake_out == 1'b0)
    else $error("open-drain drive value not low");
  a_reset_quiet: assert property (disable iff (1'b0) rst_in |=>
    !rectifier_enable_output_oe_out && !wake_oe_out && !power_cycle_detect_out)
    else $error("outputs active in lockout");
  a_detect_single: assert property (power_cycle_detect_out |=> s_quiet_det)
    else $error("detect pulses too close");
  a_detect_cause: assert property (power_cycle_detect_out |-> $past(demag_end_in) || $past(demag_end_in, 2))
    else $error("detect without demag end");
  a_wake_width: assert property ($rose(wake_oe_out) |-> s_pulse_body)
    else $error("wake pulse width wrong");
  a_wake_blanks: assert property ($fell(wake_oe_out) |-> s_quiet_det)
    else $error("detect right after wake pulse");
  a_rect_by_detect: assert property (!$past(rst_in) && $changed(rectifier_enable_output_oe_out) |->
    $past(power_cycle_detect_out) || $past(power_cycle_detect_out, 2))
    else $error("enable output moved without detect");
  a_rect_stays: assert property (!power_cycle_detect_out && !$past(power_cycle_detect_out) |=>
    $stable(rectifier_enable_output_oe_out))
    else $error("enable output unstable");
endmodule : spe_props
bind spe_switching_period_enable_counter spe_props i_spe_props (.core_clk_in, .rst_in, .demag_end_in,
  .rectifier_enable_output_oe_out, .rectifier_enable_output_out, .wake_oe_out, .wake_out, .power_cycle_detect_out);
`default_nettype wire

/* File: tb/spe_rect_ctrl_model.sv */
// Rectifier controller seen through its open-drain enable pin.
// Assumes a pull-up on the pin; the controller runs while the pin reads high.
`timescale 1ns/1ps
`default_nettype none
module spe_rect_ctrl_model (
  input  wire logic rect_oe_in,
  input  wire logic rect_drive_in,
  output var  logic pin_out,
  output var  logic running_out
);
  always_comb begin
    pin_out = rect_oe_in ? rect_drive_in : 1'b1;
    running_out = pin_out;
  end
endmodule : spe_rect_ctrl_model
`default_nettype wire

/* File: tb/spe_switching_period_enable_counter_bench.sv */
// Self-checking bench for the switching-period enable counter.
// Assumes shortened qualify intervals and a wake comparator held high except during the unqualified-detect test.
`timescale 1ns/1ps
`default_nettype none
module spe_switching_period_enable_counter_bench;
  import spe_pkg::*;
  localparam int unsigned DQ = 200;
  localparam int unsigned EQ = 40;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        below = 1'b1;
  logic        demag = 1'b0;
  logic [11:0] supply = 12'h7D0;
  logic        rect_oe, rect_d, wk_oe, wk_d, det, pin, sr_on;
  int          num_errors = 0;
  int          checked = 0;
  initial begin
    forever #25 clk = ~clk;
  end
  spe_switching_period_enable_counter #(.DISABLE_QUALIFY_CYC(DQ), .ENABLE_QUALIFY_CYC(EQ))
    i_spe_switching_period_enable_counter (.core_clk_in(clk), .rst_in(rst), .wake_below_threshold_in(below),
    .demag_end_in(demag), .supply_level_in(supply), .rectifier_enable_output_oe_out(rect_oe),
    .rectifier_enable_output_out(rect_d), .wake_oe_out(wk_oe), .wake_out(wk_d), .power_cycle_detect_out(det));
  spe_rect_ctrl_model i_spe_rect_ctrl_model (.rect_oe_in(rect_oe), .rect_drive_in(rect_d), .pin_out(pin),
    .running_out(sr_on));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  // One switching period of p cycles ending in a demag pulse
  task automatic cyc(input int p);
    repeat (p - 1) @(posedge clk);
    demag <= 1'b1;
    @(posedge clk);
    demag <= 1'b0;
  endtask : cyc
  task automatic rect_is(input string what, input logic exp);
    repeat (3) @(posedge clk);
    chk(what, rect_oe, exp);
  endtask : rect_is
  task automatic wait_wk(input logic exp);
    int n = 0;
    while (wk_oe !== exp) begin
      @(posedge clk);
      n++;
      if (n > 700) begin
        chk("wake_oe", wk_oe, exp);
        results();
      end
    end
  endtask : wait_wk
  task automatic quiet_wk(input string what, input int n);
    logic seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      seen = seen | wk_oe;
    end
    chk(what, seen, 1'b0);
  endtask : quiet_wk
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk("rect_oe", rect_oe, 1'b0);
    chk("pin", pin, 1'b1);
    chk("wake_oe", wk_oe, 1'b0);
    chk("sr_running", sr_on, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_unqual();
    below <= 1'b0;
    cyc(30);
    repeat (4) begin
      @(posedge clk);
      chk("detect", det, 1'b0);
    end
    below <= 1'b1;
    $display("test unqualified done");
  endtask : t_unqual
  task automatic t_disable();
    repeat (63) cyc(DQ + 50);
    cyc(DQ / 2);
    repeat (62) cyc(DQ + 50);
    rect_is("rect_oe after 62", 1'b0);
    cyc(DQ + 50);
    rect_is("rect_oe after 63", 1'b1);
    chk("sr_running", sr_on, 1'b0);
    $display("test disable done");
  endtask : t_disable
  task automatic t_wake();
    supply <= 12'h79E;
    cyc(DQ);
    supply <= 12'h76C;
    quiet_wk("wake above new ref", 100);
    supply <= 12'h708;
    wait_wk(1'b1);
    chk("rect_oe in wake", rect_oe, 1'b1);
    wait_wk(1'b0);
    supply <= 12'h79E;
    wait_wk(1'b1);
    wait_wk(1'b0);
    cyc(30);
    @(posedge clk);
    chk("detect", det, 1'b1);
    quiet_wk("wake after detect", 700);
    $display("test wake done");
  endtask : t_wake
  task automatic t_enable();
    for (int i = 0; i < 31; i++) begin
      cyc(DQ + 50);
      cyc(EQ - 10);
    end
    rect_is("rect_oe after 31", 1'b1);
    cyc(EQ - 10);
    rect_is("rect_oe after 32", 1'b0);
    chk("sr_running", sr_on, 1'b1);
    $display("test enable done");
  endtask : t_enable
  // Lockout in mid-run must clear the disable count and release the pin
  task automatic t_relock();
    repeat (40) cyc(DQ + 50);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    repeat (63) cyc(DQ + 50);
    rect_is("rect_oe after relock 62", 1'b0);
    cyc(DQ + 50);
    rect_is("rect_oe after relock 63", 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("rect_oe in lockout", rect_oe, 1'b0);
    chk("detect in lockout", det, 1'b0);
    rst <= 1'b0;
    @(posedge clk);
    $display("test relock done");
  endtask : t_relock
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_unqual();
    t_disable();
    t_wake();
    t_enable();
    t_relock();
    results();
  end
endmodule : spe_switching_period_enable_counter_bench
`default_nettype wire
